// *** inc/ssia_if.sv ***
`timescale 1ns/1ps
interface ssia_if;
  logic sel_n;
  logic addr;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic wait_n;
  logic wait_oe;
  logic external_analog_input_sel;
  modport device (
    input sel_n, addr, rd_n, wr_n, host_data, host_data_oe,
    output dev_data, dev_data_oe, wait_n, wait_oe,
    output external_analog_input_sel
  );
  modport host (
    output sel_n, addr, rd_n, wr_n, host_data, host_data_oe,
    input dev_data, dev_data_oe, wait_n, wait_oe,
    input external_analog_input_sel
  );
endinterface : ssia_if

// *** inc/ssia_pkg.sv ***
package ssia_pkg;
  // ---------------------------------------------------------------
  // Register indexes
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_FIRST_ROW_HIGH = 8'h00;
  localparam logic [7:0] IDX_FIRST_ROW_LOW = 8'h01;
  localparam logic [7:0] IDX_FIRST_COLUMN = 8'h02;
  localparam logic [7:0] IDX_LAST_ROW_HIGH = 8'h03;
  localparam logic [7:0] IDX_LAST_ROW_LOW = 8'h04;
  localparam logic [7:0] IDX_LAST_COLUMN = 8'h05;
  localparam logic [7:0] IDX_DISCHARGE_TIME = 8'h06;
  localparam logic [7:0] IDX_DISCHARGE_CURRENT = 8'h07;
  localparam logic [7:0] IDX_CAPTURE = 8'h08;
  localparam logic [7:0] IDX_CONTROL_B = 8'h09;
  localparam logic [7:0] IDX_CONTROL_C = 8'h0a;
  localparam logic [7:0] IDX_STATUS_A = 8'h0b;
  localparam logic [7:0] IDX_GAIN_CONTROL = 8'h0c;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0d;
  localparam logic [7:0] IDX_INTERRUPT_STATUS = 8'h0e;
  localparam logic [7:0] IDX_CHIP_IDENT_HIGH = 8'h10;
  localparam logic [7:0] IDX_CHIP_IDENT_LOW = 8'h11;
  localparam logic [7:0] IDX_FACTORY_TEST = 8'h12;
  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int BIT_ANALOG_SOURCE = 3;
  localparam int BIT_CAPTURE_REGION = 2;
  localparam int BIT_CAPTURE_FULL_IMAGE = 1;
  localparam int BIT_CAPTURE_SINGLE_ROW = 0;
  localparam logic [7:0] MASK_ROW_HIGH = 8'h01;
  localparam logic [7:0] MASK_DISCHARGE_COUNT = 8'h7f;
  localparam logic [7:0] MASK_DISCHARGE_RATE = 8'h1f;
  localparam logic [7:0] MASK_CAPTURE = 8'h0f;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [8:0] FULL_LAST_ROW = 9'h12b;
  localparam logic [7:0] FULL_LAST_COLUMN = 8'hff;
  // ---------------------------------------------------------------
  // Timing in oscillator cycles
  // ---------------------------------------------------------------
  localparam logic [7:0] FIRST_RESULT_BASE = 8'h1c;
  localparam logic [7:0] NEXT_RESULT_CYCLES = 8'h06;
  // Cycles between host bus steps (own choice of host pacing).
  localparam logic [3:0] HOST_STROBE_CYCLES = 4'h2;
endpackage : ssia_pkg

// *** logic/ssia_device.sv ***
`timescale 1ns/1ps
module ssia_device
  import ssia_pkg::*;
#(
  parameter logic [7:0] CHIP_IDENT_HIGH_VALUE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] CHIP_IDENT_LOW_VALUE = 8'ha5 // Arbitrary value.
)(
  input wire logic clk_i,
  input wire logic resetn_i,
  ssia_if.device bus,
  input wire logic [7:0] sample_i,
  output logic [8:0] row_o,
  output logic [7:0] column_o,
  output logic [6:0] discharge_count_o,
  output logic [4:0] discharge_rate_o,
  output logic converting_o,
  output logic scan_active_o
);
  typedef enum logic [1:0] {SSIA_IDLE, SSIA_CONVERT, SSIA_DONE}
    ssia_state_type;
  typedef struct packed {
    ssia_state_type state;
    logic [7:0] index;
    logic [7:0] first_row_high;
    logic [7:0] first_row_low;
    logic [7:0] first_column;
    logic [7:0] last_row_high;
    logic [7:0] last_row_low;
    logic [7:0] last_column;
    logic [7:0] discharge_time;
    logic [7:0] discharge_current;
    logic [7:0] control_b;
    logic [7:0] control_c;
    logic [7:0] gain_control;
    logic [7:0] interrupt_control;
    logic [7:0] interrupt_status;
    logic [7:0] factory_test;
    logic analog_source_select;
    logic [8:0] row;
    logic [7:0] column;
    logic [8:0] row_first;
    logic [8:0] row_last;
    logic [7:0] col_first;
    logic [7:0] col_last;
    logic scanning;
    logic [7:0] countdown;
    logic [7:0] result;
    logic rd_n_q;
    logic wr_n_q;
    logic reading_capture;
  } ssia_reg_type;

  ssia_reg_type r;
  ssia_reg_type next_r;
  logic selected;
  logic rd_rise;
  logic wr_rise;
  logic [7:0] read_value;
  logic [2:0] starts;

  assign selected = !bus.sel_n;
  assign rd_rise = bus.rd_n && !r.rd_n_q;
  assign wr_rise = bus.wr_n && !r.wr_n_q;
  assign starts = bus.host_data[2:0];

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always_comb
  begin
    read_value = RESET_VALUE;
    if (!bus.addr)
    begin
      read_value = r.index;
    end
    else
    begin
      case (r.index)
        IDX_FIRST_ROW_HIGH: read_value = r.first_row_high;
        IDX_FIRST_ROW_LOW: read_value = r.first_row_low;
        IDX_FIRST_COLUMN: read_value = r.first_column;
        IDX_LAST_ROW_HIGH: read_value = r.last_row_high;
        IDX_LAST_ROW_LOW: read_value = r.last_row_low;
        IDX_LAST_COLUMN: read_value = r.last_column;
        IDX_DISCHARGE_TIME: read_value = r.discharge_time;
        IDX_DISCHARGE_CURRENT: read_value = r.discharge_current;
        IDX_CAPTURE: read_value = r.result;
        IDX_CONTROL_B: read_value = r.control_b;
        IDX_CONTROL_C: read_value = r.control_c;
        IDX_STATUS_A: read_value = {7'h00, r.state == SSIA_CONVERT};
        IDX_GAIN_CONTROL: read_value = r.gain_control;
        IDX_INTERRUPT_CONTROL: read_value = r.interrupt_control;
        IDX_INTERRUPT_STATUS: read_value = r.interrupt_status;
        IDX_CHIP_IDENT_HIGH: read_value = CHIP_IDENT_HIGH_VALUE;
        IDX_CHIP_IDENT_LOW: read_value = CHIP_IDENT_LOW_VALUE;
        IDX_FACTORY_TEST: read_value = r.factory_test;
        default: read_value = RESET_VALUE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.rd_n_q = bus.rd_n;
    next_r.wr_n_q = bus.wr_n;
    if (selected && !bus.rd_n && bus.addr && r.index == IDX_CAPTURE)
    begin
      next_r.reading_capture = 1'b1;
    end
    // Stopping at two absorbs the cycle taken to detect the strobe edge.
    if (r.state == SSIA_CONVERT)
    begin
      if (r.countdown <= 8'h02)
      begin
        next_r.result = sample_i;
        next_r.state = SSIA_DONE;
      end
      else
      begin
        next_r.countdown = r.countdown - 8'h01;
      end
    end
    // The end of a capture read launches the next pixel.
    if (rd_rise && r.reading_capture)
    begin
      next_r.reading_capture = 1'b0;
      if (r.scanning && r.state == SSIA_DONE)
      begin
        if (r.column == r.col_last)
        begin
          next_r.column = r.col_first;
          if (r.row == r.row_last)
          begin
            next_r.scanning = 1'b0;
            next_r.state = SSIA_IDLE;
          end
          else
          begin
            next_r.row = r.row + 9'h001;
            next_r.state = SSIA_CONVERT;
            next_r.countdown = NEXT_RESULT_CYCLES;
          end
        end
        else
        begin
          next_r.column = r.column + 8'h01;
          next_r.state = SSIA_CONVERT;
          next_r.countdown = NEXT_RESULT_CYCLES;
        end
      end
    end
    // Writes land on the trailing edge of the write strobe.
    if (wr_rise && selected)
    begin
      if (!bus.addr)
      begin
        next_r.index = bus.host_data;
      end
      else
      begin
        case (r.index)
          IDX_FIRST_ROW_HIGH:
            next_r.first_row_high = bus.host_data & MASK_ROW_HIGH;
          IDX_FIRST_ROW_LOW: next_r.first_row_low = bus.host_data;
          IDX_FIRST_COLUMN: next_r.first_column = bus.host_data;
          IDX_LAST_ROW_HIGH:
            next_r.last_row_high = bus.host_data & MASK_ROW_HIGH;
          IDX_LAST_ROW_LOW: next_r.last_row_low = bus.host_data;
          IDX_LAST_COLUMN: next_r.last_column = bus.host_data;
          IDX_DISCHARGE_TIME:
            next_r.discharge_time = bus.host_data & MASK_DISCHARGE_COUNT;
          IDX_DISCHARGE_CURRENT:
            next_r.discharge_current = bus.host_data & MASK_DISCHARGE_RATE;
          IDX_CAPTURE:
          begin
            next_r.analog_source_select = bus.host_data[BIT_ANALOG_SOURCE];
            if ($onehot(starts))
            begin
              next_r.scanning = 1'b1;
              next_r.state = SSIA_CONVERT;
              next_r.countdown = FIRST_RESULT_BASE
                + {1'b0, r.discharge_time[6:0]};
              next_r.row_first = {r.first_row_high[0], r.first_row_low};
              next_r.row = next_r.row_first;
              next_r.row_last = next_r.row_first;
              next_r.col_first = 8'h00;
              next_r.col_last = FULL_LAST_COLUMN;
              if (starts[BIT_CAPTURE_REGION])
              begin
                next_r.col_first = r.first_column;
                next_r.row_last = {r.last_row_high[0], r.last_row_low};
                next_r.col_last = r.last_column;
              end
              if (starts[BIT_CAPTURE_FULL_IMAGE])
              begin
                next_r.row = 9'h000;
                next_r.row_last = FULL_LAST_ROW;
                next_r.col_first = 8'h00;
                next_r.col_last = FULL_LAST_COLUMN;
              end
              next_r.column = next_r.col_first;
            end
          end
          IDX_CONTROL_B: next_r.control_b = bus.host_data;
          IDX_CONTROL_C: next_r.control_c = bus.host_data;
          IDX_GAIN_CONTROL: next_r.gain_control = bus.host_data;
          IDX_INTERRUPT_CONTROL: next_r.interrupt_control = bus.host_data;
          IDX_INTERRUPT_STATUS: next_r.interrupt_status = bus.host_data;
          IDX_FACTORY_TEST: next_r.factory_test = bus.host_data;
          default: next_r.index = r.index;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r <= '0;
      r.rd_n_q <= 1'b1;
      r.wr_n_q <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.dev_data = read_value;
  assign bus.dev_data_oe = selected && !bus.rd_n;
  // Wait is open-drain: only ever driven low.
  assign bus.wait_n = 1'b0;
  assign bus.wait_oe = selected && !bus.rd_n && bus.addr
    && r.index == IDX_CAPTURE && r.state == SSIA_CONVERT;
  assign bus.external_analog_input_sel = r.analog_source_select;
  assign row_o = r.row;
  assign column_o = r.column;
  assign discharge_count_o = r.discharge_time[6:0];
  assign discharge_rate_o = r.discharge_current[4:0];
  assign converting_o = r.state == SSIA_CONVERT;
  assign scan_active_o = r.scanning;
endmodule : ssia_device

// *** logic/ssia_host.sv ***
`timescale 1ns/1ps
module ssia_host
  import ssia_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  ssia_if.host bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_index_i,
  input wire logic [7:0] req_data_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic [7:0] resp_data_o
);
  typedef enum logic [2:0] {
    SSIH_IDLE, SSIH_IDX_LOW, SSIH_IDX_HIGH,
    SSIH_DATA_LOW, SSIH_WAIT_DATA, SSIH_DATA_HIGH
  } ssih_state_type;
  typedef struct packed {
    ssih_state_type state;
    logic write;
    logic [7:0] index;
    logic [7:0] data;
    logic [3:0] timer;
    logic resp_valid;
    logic [7:0] resp_data;
  } ssih_reg_type;

  ssih_reg_type r;
  ssih_reg_type next_r;
  logic wait_low;

  // Wait is low only while the device drives it.
  assign wait_low = bus.wait_oe && !bus.wait_n;

  // ---------------------------------------------------------------
  // Index then data sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.resp_valid = 1'b0;
    case (r.state)
      SSIH_IDLE:
        if (req_valid_i)
        begin
          next_r.write = req_write_i;
          next_r.index = req_index_i;
          // Reserved bits are cleared here so the device never sees them set.
          case (req_index_i)
            IDX_FIRST_ROW_HIGH, IDX_LAST_ROW_HIGH:
              next_r.data = req_data_i & MASK_ROW_HIGH;
            IDX_DISCHARGE_TIME:
              next_r.data = req_data_i & MASK_DISCHARGE_COUNT;
            IDX_DISCHARGE_CURRENT:
              next_r.data = req_data_i & MASK_DISCHARGE_RATE;
            IDX_CAPTURE: next_r.data = req_data_i & MASK_CAPTURE;
            default: next_r.data = req_data_i;
          endcase
          next_r.timer = HOST_STROBE_CYCLES;
          next_r.state = SSIH_IDX_LOW;
        end
      SSIH_IDX_LOW:
        if (r.timer == 4'h0)
        begin
          next_r.timer = HOST_STROBE_CYCLES;
          next_r.state = SSIH_IDX_HIGH;
        end
        else
        begin
          next_r.timer = r.timer - 4'h1;
        end
      SSIH_IDX_HIGH:
        if (r.timer == 4'h0)
        begin
          next_r.timer = HOST_STROBE_CYCLES;
          next_r.state = SSIH_DATA_LOW;
        end
        else
        begin
          next_r.timer = r.timer - 4'h1;
        end
      SSIH_DATA_LOW:
        if (r.timer == 4'h0)
        begin
          next_r.state = SSIH_WAIT_DATA;
        end
        else
        begin
          next_r.timer = r.timer - 4'h1;
        end
      SSIH_WAIT_DATA:
        // A read of a busy converter is stretched until wait releases.
        if (r.write || !wait_low)
        begin
          next_r.resp_data = bus.dev_data;
          next_r.timer = HOST_STROBE_CYCLES;
          next_r.state = SSIH_DATA_HIGH;
        end
      SSIH_DATA_HIGH:
        if (r.timer == 4'h0)
        begin
          next_r.resp_valid = 1'b1;
          next_r.state = SSIH_IDLE;
        end
        else
        begin
          next_r.timer = r.timer - 4'h1;
        end
      default: next_r.state = SSIH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Bus drive
  // ---------------------------------------------------------------
  assign bus.sel_n = r.state == SSIH_IDLE;
  assign bus.addr = r.state == SSIH_DATA_LOW || r.state == SSIH_WAIT_DATA
    || r.state == SSIH_DATA_HIGH;
  assign bus.wr_n = !(r.state == SSIH_IDX_LOW
    || (r.write && (r.state == SSIH_DATA_LOW
    || r.state == SSIH_WAIT_DATA)));
  assign bus.rd_n = !(!r.write && (r.state == SSIH_DATA_LOW
    || r.state == SSIH_WAIT_DATA));
  assign bus.host_data = (r.state == SSIH_IDX_LOW
    || r.state == SSIH_IDX_HIGH) ? r.index : r.data;
  assign bus.host_data_oe = !bus.wr_n;
  assign req_ready_o = r.state == SSIH_IDLE;
  assign resp_valid_o = r.resp_valid;
  assign resp_data_o = r.resp_data;
endmodule : ssia_host

// *** verif/ssia_assertions.sv ***
`timescale 1ns/1ps
module ssia_assertions (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sel_n,
  input wire logic addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic wait_n,
  input wire logic wait_oe,
  input wire logic external_analog_input_sel
);
  // ---------------------------------------------------------------
  // Bus rules
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  oe_decode_a: assert property (dev_data_oe == (!sel_n && !rd_n))
    else $error("device drive enable does not follow read select");
  no_contention_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data bus");
  strobe_select_a: assert property ((!rd_n || !wr_n) |-> !sel_n)
    else $error("strobe low while not selected");
  single_strobe_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  write_hold_a: assert property ($fell(wr_n) |-> !wr_n [*3])
    else $error("write strobe shorter than three cycles");
  write_steady_a: assert property ((!wr_n && !$past(wr_n))
    |-> $stable(addr) && $stable(host_data))
    else $error("address or data moved under write strobe");
  wait_level_a: assert property (wait_oe |-> !wait_n)
    else $error("wait line driven high");
  wait_cause_a: assert property (wait_oe |-> !sel_n && !rd_n && addr)
    else $error("wait without a data read");
  // The longest first conversion is 28 plus 127 cycles; slack for pacing.
  wait_bound_a: assert property ($rose(wait_oe)
    |-> ##[1:200] !wait_oe)
    else $error("wait held beyond conversion bound");
  cover property ($rose(wait_oe));
  cover property ($rose(external_analog_input_sel));
  cover property ($rose(wr_n) && addr);
  cover property ($rose(rd_n) && addr);
endmodule : ssia_assertions

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ssia_pkg::*;
  localparam logic [7:0] ID_HIGH = 8'h3c; // Arbitrary value.
  localparam logic [7:0] ID_LOW = 8'hc3; // Arbitrary value.
  logic clk_i, resetn_i, req_valid_i, req_write_i, req_ready_o;
  logic resp_valid_o, converting_o, scan_active_o;
  logic [7:0] req_index_i, req_data_i, resp_data_o, sample_i, latched, v;
  logic [8:0] row_o, note;
  logic [7:0] column_o;
  logic [6:0] discharge_count_o;
  logic [4:0] discharge_rate_o;
  logic [8:0] exp_q[$];
  logic [7:0] idx_tab[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h0c, 8'h0a, 8'h12};
  logic [7:0] mask_tab[11] = '{8'h01, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff,
    8'h7f, 8'h1f, 8'hff, 8'hff, 8'hff};
  logic [7:0] multi_tab[4] = '{8'h03, 8'h05, 8'h06, 8'h07};
  int bad_count = 0;
  int n_checks = 0;
  int n;
  ssia_if bus_if();
  ssia_device #(.CHIP_IDENT_HIGH_VALUE(ID_HIGH),
    .CHIP_IDENT_LOW_VALUE(ID_LOW)) u_ssia_device (.clk_i(clk_i),
    .resetn_i(resetn_i), .bus(bus_if), .sample_i(sample_i), .row_o(row_o),
    .column_o(column_o), .discharge_count_o(discharge_count_o),
    .discharge_rate_o(discharge_rate_o), .converting_o(converting_o),
    .scan_active_o(scan_active_o));
  ssia_host u_ssia_host (.clk_i(clk_i), .resetn_i(resetn_i), .bus(bus_if),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_index_i(req_index_i), .req_data_i(req_data_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o),
    .resp_data_o(resp_data_o));
  ssia_assertions u_ssia_assertions (.clk_i(clk_i), .resetn_i(resetn_i),
    .sel_n(bus_if.sel_n), .addr(bus_if.addr), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n), .host_data(bus_if.host_data),
    .host_data_oe(bus_if.host_data_oe), .dev_data(bus_if.dev_data),
    .dev_data_oe(bus_if.dev_data_oe), .wait_n(bus_if.wait_n),
    .wait_oe(bus_if.wait_oe),
    .external_analog_input_sel(bus_if.external_analog_input_sel));
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check_resp(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch read_data expected %h seen %h", exp, got);
    end
  endtask : check_resp
  task automatic check_port(input string what, input logic [8:0] exp,
    input logic [8:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_port
  // Reads queue their expectation; writes queue a note with no check bit.
  task automatic access(input logic w, input logic [7:0] idx,
    input logic [7:0] d, input logic [8:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_index_i <= idx;
    req_data_i <= d;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(negedge clk_i);
    while (req_ready_o !== 1'b1)
      @(negedge clk_i);
  endtask : access
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    access(1'b1, idx, d, 9'h000);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    access(1'b0, idx, 8'h00, {1'b1, exp});
  endtask : rd
  task automatic start(input logic [7:0] code);
    wr(IDX_CAPTURE, code);
    latched = sample_i;
  endtask : start
  // The converter input only changes once the running conversion is over.
  task automatic pix(input logic [8:0] row, input logic [7:0] col);
    check_port("row", row, row_o);
    check_port("column", {1'b0, col}, {1'b0, column_o});
    rd(IDX_CAPTURE, latched);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check_port("busy", 9'h000, {8'h00, converting_o});
    latched = sample_i;
    @(posedge clk_i);
    sample_i <= 8'($urandom);
    @(negedge clk_i);
  endtask : pix
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  always @(negedge clk_i)
    if (resp_valid_o === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[8])
        check_resp(note[7:0], resp_data_o);
    end
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    resetn_i = 1'b0;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_index_i = 8'h00;
    req_data_i = 8'h00;
    sample_i = 8'h00;
    v = 8'($urandom(32'h90d1));
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    sample_i <= 8'($urandom);
    @(negedge clk_i);
    for (int i = 0; i < 9; i++)
      rd(8'(i), RESET_VALUE);
    rd(IDX_CHIP_IDENT_HIGH, ID_HIGH);
    rd(IDX_CHIP_IDENT_LOW, ID_LOW);
    $display("test reset_values done");
    foreach (idx_tab[i])
    begin
      v = 8'($urandom);
      wr(idx_tab[i], v);
      rd(idx_tab[i], v & mask_tab[i]);
    end
    wr(IDX_DISCHARGE_TIME, 8'h94);
    wr(IDX_DISCHARGE_CURRENT, 8'he9);
    check_port("count", 9'h014, {2'b00, discharge_count_o});
    check_port("rate", 9'h009, {4'h0, discharge_rate_o});
    wr(IDX_CHIP_IDENT_HIGH, ~ID_HIGH);
    rd(IDX_CHIP_IDENT_HIGH, ID_HIGH);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'h00);
    $display("test registers done");
    wr(IDX_FIRST_ROW_HIGH, 8'h01);
    wr(IDX_FIRST_ROW_LOW, 8'h2a);
    wr(IDX_FIRST_COLUMN, 8'hfe);
    wr(IDX_LAST_ROW_HIGH, 8'h01);
    wr(IDX_LAST_ROW_LOW, 8'h2b);
    wr(IDX_LAST_COLUMN, 8'hff);
    // Parallel bus, not USB: a two-column region is legal.
    start(8'h04);
    pix(9'h12a, 8'hfe);
    pix(9'h12a, 8'hff);
    pix(9'h12b, 8'hfe);
    pix(9'h12b, 8'hff);
    check_port("active", 9'h000, {8'h00, scan_active_o});
    $display("test region done");
    foreach (multi_tab[i])
    begin
      wr(IDX_CAPTURE, multi_tab[i]);
      check_port("active", 9'h000, {8'h00, scan_active_o});
      check_port("busy", 9'h000, {8'h00, converting_o});
    end
    $display("test multiple_starts done");
    start(8'h02);
    check_port("row", 9'h000, row_o);
    check_port("busy", 9'h001, {8'h00, converting_o});
    n = 0;
    while (converting_o === 1'b1 && n < 300)
    begin
      @(negedge clk_i);
      n++;
    end
    check_port("latency", 9'h001, {8'h00, n + 3 <= 28 + 20});
    pix(9'h000, 8'h00);
    pix(9'h000, 8'h01);
    start(8'h0a);
    check_port("source", 9'h001,
      {8'h00, bus_if.external_analog_input_sel});
    pix(9'h000, 8'h00);
    wr(IDX_CAPTURE, 8'h00);
    check_port("source", 9'h000,
      {8'h00, bus_if.external_analog_input_sel});
    check_port("active", 9'h001, {8'h00, scan_active_o});
    pix(9'h000, 8'h01);
    $display("test full_image done");
    start(8'h01);
    pix(9'h12a, 8'h00);
    pix(9'h12a, 8'h01);
    $display("test single_row done");
    end_sim();
  end
endmodule : testbench
